// [core/pvcr_pkg.sv]
// constants for the port virtual channel capability register bank
package pvcr_pkg;

  // bus widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register indexes as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CAP_ONE  = 12'h204;
  localparam logic [ADDR_W-1:0] IDX_CAP_TWO  = 12'h208;
  localparam logic [ADDR_W-1:0] IDX_CONTROL  = 12'h20c;
  localparam logic [ADDR_W-1:0] IDX_STATUS   = 12'h20e;
  localparam logic [ADDR_W-1:0] IDX_VCR0_CAP = 12'h210;

  // field positions
  localparam int unsigned LPEVC_LSB    = 4;
  localparam int unsigned LPEVC_MSB    = 6;
  localparam int unsigned VCARB_LSB    = 0;
  localparam int unsigned VCARB_MSB    = 7;
  localparam int unsigned TBLOFF_LSB   = 24;
  localparam int unsigned TBLOFF_MSB   = 31;
  localparam int unsigned LOAD_BIT     = 0;
  localparam int unsigned SEL_LSB      = 1;
  localparam int unsigned SEL_MSB      = 3;
  localparam int unsigned TBLSTS_BIT   = 0;
  localparam int unsigned PARB_LSB     = 0;
  localparam int unsigned PARB_MSB     = 7;
  localparam int unsigned ADV_SW_BIT   = 14;
  localparam int unsigned SNOOP_BIT    = 15;

  // table offset unit in bytes
  localparam int unsigned TBLOFF_UNIT_BYTES = 16;

  // fixed field values
  localparam logic [2:0] LPEVC_COUNT_VAL   = 3'h0;
  localparam logic [7:0] VCARB_SUPPORT_VAL = 8'h00;
  localparam logic [7:0] VCARB_TBLOFF_VAL  = 8'h00;
  localparam logic       LOAD_TBL_VAL      = 1'b0;
  localparam logic       TBL_STATUS_VAL    = 1'b0;
  localparam logic       ADV_SW_VAL        = 1'b0;
  localparam logic       SNOOP_VAL         = 1'b0;

  // port arbitration capability bit meanings
  localparam int unsigned PARB_FIXED_RR = 0;
  localparam int unsigned PARB_WRR32    = 1;
  localparam int unsigned PARB_WRR64    = 2;
  localparam int unsigned PARB_WRR128   = 3;
  localparam int unsigned PARB_TWRR128  = 4;
  localparam int unsigned PARB_WRR256   = 5;
  localparam logic [7:0]  PARB_UP_VAL   = 8'h03;
  localparam logic [7:0]  PARB_DOWN_VAL = 8'h01;

  // reset values
  localparam logic [2:0]        SEL_RST   = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // strap synchroniser settle count before capture
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// [core/pvcr_strap.sv]
// two-flop synchroniser and one-time capture of the port role strap
`timescale 1ns/10ps
module pvcr_strap (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // strap pin
  input  wire logic strap_i,
  // captured role
  output logic      upstream_o,
  output logic      valid_o
);

  typedef struct packed {
    logic       sync_a;
    logic       sync_b;
    logic [1:0] settle;
    logic       role;
    logic       done;
  } pvcr_strap_state_t;

  pvcr_strap_state_t state;
  pvcr_strap_state_t next_state;

  // capture once after the synchroniser has filled; later pin moves are ignored
  always_comb begin
    next_state        = state;
    next_state.sync_a = strap_i;
    next_state.sync_b = state.sync_a;
    if (!state.done) begin
      if (state.settle == pvcr_pkg::STRAP_SETTLE) begin
        next_state.role = state.sync_b;
        next_state.done = 1'b1;
      end else begin
        next_state.settle = state.settle + 2'h1;
      end
    end
  end

  // constant reset only; the pin is never loaded under reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign upstream_o = state.role;
  assign valid_o    = state.done;

endmodule

// [core/pvcr_regs.sv]
// port virtual channel capability register bank behind an apb slave
// Summary of operation
// RULE1: 8-bit read-only vc arbitration capability; bit 0 rr, 1-3 wrr 32/64/128, 4-7 reserved.
// RULE2: that field is only meaningful with a nonzero low-priority vc count, so it reads zero.
// RULE3: vc arbitration table offset in bits 31:24 counts 16-byte units from capability base.
// RULE4: the vc arbitration table offset reads zero, meaning no table.
// RULE5: the load-table control bit 0 is read-only, has no effect and reads zero.
// RULE6: the 3-bit arbitration select in bits 3:1 stores what is written and does nothing else.
// RULE7: the table status bit 0 of the status register is read-only and always zero.
// RULE8: port arbitration capability reads 0x3 on the upstream port and 0x1 on downstream ports; the upstream port reads 0x1 until its strap is captured.
// RULE9: port arbitration bits: 0 round robin, 1-3 wrr 32/64/128, 4 time-based 128, 5 wrr 256.
// RULE10: several capability bits are set together when several schemes are supported.
// RULE11: the advanced packet switching flag in bit 14 reads zero and is read-only.
// RULE12: the reject snoop flag in bit 15 reads zero and is read-only.
// RULE13: low-priority extended vc count in bits 6:4 of the first capability register is zero.
// RULE14: reserved fields read zero and writes to read-only or reserved bits are ignored.
`timescale 1ns/10ps
module pvcr_regs (
  // clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        RST_N_I,
  // port role strap, high on the upstream port
  input  wire logic                        UPSTREAM_STRAP_I,
  // apb slave
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [pvcr_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [pvcr_pkg::DATA_W-1:0] PWDATA_I,
  input  wire logic [3:0]                  PSTRB_I,
  output logic      [pvcr_pkg::DATA_W-1:0] PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  // arbitration select as stored
  output logic      [2:0]                  VC_ARB_SCHEME_SELECT_O
);

  typedef struct packed {
    logic [2:0]                  vc_arb_scheme_select;
    logic [pvcr_pkg::DATA_W-1:0] rdata;
    logic                        ready;
    logic                        slverr;
  } pvcr_state_t;

  pvcr_state_t state;
  pvcr_state_t next_state;

  logic upstream;
  logic strap_valid;

  logic [pvcr_pkg::ADDR_W-1:0] a_cap_one;
  logic [pvcr_pkg::ADDR_W-1:0] a_cap_two;
  logic [pvcr_pkg::ADDR_W-1:0] a_control;
  logic [pvcr_pkg::ADDR_W-1:0] a_status;
  logic [pvcr_pkg::ADDR_W-1:0] a_vcr0_cap;

  logic [pvcr_pkg::DATA_W-1:0] cap_one_word;
  logic [pvcr_pkg::DATA_W-1:0] cap_two_word;
  logic [pvcr_pkg::DATA_W-1:0] control_word;
  logic [pvcr_pkg::DATA_W-1:0] status_word;
  logic [pvcr_pkg::DATA_W-1:0] vcr0_cap_word;
  logic [7:0]                  port_arb_scheme_support;

  logic                        setup;
  logic                        access_done;
  logic                        hit;
  logic [pvcr_pkg::DATA_W-1:0] read_word;

  // role strap enters through its own synchroniser
  pvcr_strap u_strap (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .strap_i    (UPSTREAM_STRAP_I),
    .upstream_o (upstream),
    .valid_o    (strap_valid)
  );

  // byte addresses are four times the printed index
  assign a_cap_one  = pvcr_pkg::IDX_CAP_ONE << 2;
  assign a_cap_two  = pvcr_pkg::IDX_CAP_TWO << 2;
  assign a_control  = pvcr_pkg::IDX_CONTROL << 2;
  assign a_status   = pvcr_pkg::IDX_STATUS << 2;
  assign a_vcr0_cap = pvcr_pkg::IDX_VCR0_CAP << 2;

  // role picks the capability; downstream value holds until the strap is caught
  always_comb begin
    port_arb_scheme_support = pvcr_pkg::PARB_DOWN_VAL; // RULE8
    if (strap_valid && upstream) begin
      port_arb_scheme_support = pvcr_pkg::PARB_UP_VAL; // RULE8 RULE10
    end
  end

  // read views; every bit not named is reserved and stays zero
  always_comb begin
    cap_one_word  = '0; // RULE14
    cap_one_word[pvcr_pkg::LPEVC_MSB:pvcr_pkg::LPEVC_LSB] = pvcr_pkg::LPEVC_COUNT_VAL; // RULE13
    cap_two_word  = '0; // RULE14
    // no low-priority vcs, so no scheme is reported
    cap_two_word[pvcr_pkg::VCARB_MSB:pvcr_pkg::VCARB_LSB] =
      pvcr_pkg::VCARB_SUPPORT_VAL; // RULE1 RULE2
    // offset in 16-byte units; zero means no table
    cap_two_word[pvcr_pkg::TBLOFF_MSB:pvcr_pkg::TBLOFF_LSB] =
      pvcr_pkg::VCARB_TBLOFF_VAL; // RULE3 RULE4
    control_word  = '0; // RULE14
    control_word[pvcr_pkg::LOAD_BIT] = pvcr_pkg::LOAD_TBL_VAL; // RULE5
    control_word[pvcr_pkg::SEL_MSB:pvcr_pkg::SEL_LSB] = state.vc_arb_scheme_select; // RULE6
    status_word   = '0; // RULE14
    status_word[pvcr_pkg::TBLSTS_BIT] = pvcr_pkg::TBL_STATUS_VAL; // RULE7
    vcr0_cap_word = '0; // RULE14
    vcr0_cap_word[pvcr_pkg::PARB_MSB:pvcr_pkg::PARB_LSB] = port_arb_scheme_support; // RULE9
    vcr0_cap_word[pvcr_pkg::ADV_SW_BIT] = pvcr_pkg::ADV_SW_VAL; // RULE11
    vcr0_cap_word[pvcr_pkg::SNOOP_BIT] = pvcr_pkg::SNOOP_VAL; // RULE12
  end

  // address decode
  always_comb begin
    hit       = 1'b1;
    read_word = '0;
    case (PADDR_I)
      a_cap_one:  read_word = cap_one_word;
      a_cap_two:  read_word = cap_two_word;
      a_control:  read_word = control_word;
      a_status:   read_word = status_word;
      a_vcr0_cap: read_word = vcr0_cap_word;
      default:    hit = 1'b0;
    endcase
  end

  // answer is prepared in setup so pready is high in the first access cycle
  assign setup       = PSEL_I && !PENABLE_I;
  assign access_done = PSEL_I && PENABLE_I && state.ready;

  always_comb begin
    next_state        = state;
    next_state.ready  = 1'b0;
    next_state.slverr = 1'b0;
    next_state.rdata  = '0;
    if (setup) begin
      next_state.ready  = 1'b1;
      next_state.slverr = !hit;
      // reads of write transfers return zero to keep prdata quiet
      if (!PWRITE_I && hit) begin
        next_state.rdata = read_word;
      end
    end
    // only the select field takes writes; all else ignores them
    if (access_done && PWRITE_I && PADDR_I == a_control && PSTRB_I[0]) begin
      next_state.vc_arb_scheme_select =
        PWDATA_I[pvcr_pkg::SEL_MSB:pvcr_pkg::SEL_LSB]; // RULE6 RULE14
    end
  end

  // single register for all state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state.vc_arb_scheme_select <= pvcr_pkg::SEL_RST;
      state.rdata                <= pvcr_pkg::RDATA_RST;
      state.ready                <= 1'b0;
      state.slverr               <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign PRDATA_O               = state.rdata;
  assign PREADY_O               = state.ready;
  assign PSLVERR_O              = state.slverr;
  assign VC_ARB_SCHEME_SELECT_O = state.vc_arb_scheme_select;

endmodule

// [tb/pvcr_regs_sva.sv]
// concurrent checks on the ports of the vc capability register bank
`timescale 1ns/10ps
module pvcr_regs_sva (
  // clock and reset
  input wire logic                        CLK_I,
  input wire logic                        RST_N_I,
  input wire logic                        UPSTREAM_STRAP_I,
  // apb slave
  input wire logic                        PSEL_I,
  input wire logic                        PENABLE_I,
  input wire logic                        PWRITE_I,
  input wire logic [pvcr_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [pvcr_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [3:0]                  PSTRB_I,
  input wire logic [pvcr_pkg::DATA_W-1:0] PRDATA_O,
  input wire logic                        PREADY_O,
  input wire logic                        PSLVERR_O,
  input wire logic [2:0]                  VC_ARB_SCHEME_SELECT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // helper terms; the strobe gate matters since lane 0 carries the select
  logic       rd_ok;
  logic       sel_wr;
  logic [2:0] wsel;
  assign rd_ok  = PREADY_O && !PWRITE_I;
  assign sel_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == 12'h830 && PSTRB_I[0];
  assign wsel   = PWDATA_I[3:1];
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
  zero_wait_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("ready late");
  idle_data_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("data not idle");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O) else $error("error alone");
  port_cap_a: assert property (rd_ok && PADDR_I == 12'h840 |->
    (PRDATA_O == 32'h3 || PRDATA_O == 32'h1)) else $error("port cap wrong");
  ctrl_read_a: assert property (rd_ok && PADDR_I == 12'h830 |->
    PRDATA_O == {28'h0, VC_ARB_SCHEME_SELECT_O, 1'b0}) else $error("control read wrong");
  fixed_zero_a: assert property (rd_ok && (PADDR_I == 12'h810 || PADDR_I == 12'h820
    || PADDR_I == 12'h838) |-> PRDATA_O == 32'h0) else $error("fixed reg nonzero");
  sel_store_a: assert property (sel_wr |=> VC_ARB_SCHEME_SELECT_O == $past(wsel))
    else $error("select not stored");
  sel_hold_a: assert property (!sel_wr |=> $stable(VC_ARB_SCHEME_SELECT_O))
    else $error("select changed");
  // main scenarios
  cap_rd_c: cover property (rd_ok && PADDR_I == 12'h840);
  sel_wr_c: cover property (sel_wr);
  err_c: cover property (PSLVERR_O);
endmodule
bind pvcr_regs pvcr_regs_sva pvcr_regs_sva_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .UPSTREAM_STRAP_I(UPSTREAM_STRAP_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .VC_ARB_SCHEME_SELECT_O(VC_ARB_SCHEME_SELECT_O));

// [tb/port_vc_capability_regs_test.sv]
// self-checking bench for the vc capability register bank
`timescale 1ns/10ps
module port_vc_capability_regs_test;
  typedef struct {
    logic [11:0] a; logic w; logic [31:0] d; logic [3:0] s; logic [31:0] r; logic e;
  } pvcr_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        strap = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  sel;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          checked = 0;
  // downstream rows, run back to back with select held high between them
  pvcr_row_t rows [0:14] = '{
    '{12'h810, 0, 32'h0, 4'hf, 32'h0, 0}, '{12'h820, 0, 32'h0, 4'hf, 32'h0, 0},
    '{12'h838, 0, 32'h0, 4'hf, 32'h0, 0}, '{12'h840, 0, 32'h0, 4'hf, 32'h1, 0},
    '{12'h830, 1, 32'hffffffff, 4'hf, 32'h0, 0}, '{12'h830, 0, 32'h0, 4'hf, 32'he, 0},
    '{12'h830, 1, 32'h00000004, 4'h0, 32'h0, 0}, '{12'h830, 0, 32'h0, 4'hf, 32'he, 0},
    '{12'h840, 1, 32'hffffffff, 4'hf, 32'h0, 0}, '{12'h840, 0, 32'h0, 4'hf, 32'h1, 0},
    '{12'h820, 1, 32'hffffffff, 4'hf, 32'h0, 0}, '{12'h820, 0, 32'h0, 4'hf, 32'h0, 0},
    '{12'h844, 0, 32'h0, 4'hf, 32'h0, 1}, '{12'h830, 1, 32'h0000000a, 4'hf, 32'h0, 0},
    '{12'h830, 0, 32'h0, 4'hf, 32'ha, 0}};
  pvcr_regs pvcr_regs_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .UPSTREAM_STRAP_I(strap), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .VC_ARB_SCHEME_SELECT_O(sel));
  always #10 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; called right after a rising edge, more keeps psel for the next setup
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, input bit more, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      end_sim();
    end
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
    if (!more) psel <= 1'b0;
  endtask
  task automatic do_reset(input logic up);
    rst_n <= 1'b0; strap <= up;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    do_reset(1'b0);
    chk("sel after reset", 32'h0, {29'h0, sel});
    chk("ready after reset", 32'h0, {31'h0, pready});
    $display("test reset done");
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d, rows[i].s, i != 14, rd, er);
      if (!rows[i].w) chk("read data", rows[i].r, rd);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
    end
    @(posedge clk);
    chk("sel output", 32'h5, {29'h0, sel});
    $display("test table done");
    // select left nonzero so the second reset has something to clear
    apb(12'h830, 1'b1, 32'hfffffff5, 4'hf, 1'b1, rd, er);
    apb(12'h830, 1'b0, 32'h0, 4'hf, 1'b0, rd, er);
    chk("control reserved", 32'h4, rd);
    $display("test reserved done");
    @(posedge clk);
    do_reset(1'b1);
    chk("sel after second reset", 32'h0, {29'h0, sel});
    apb(12'h840, 1'b0, 32'h0, 4'hf, 1'b0, rd, er);
    chk("upstream cap", 32'h3, rd);
    $display("test upstream done");
    end_sim();
  end
endmodule
